//--- common/cpf_pkg.sv
// cpf_pkg.sv : constants and types shared by the pwm channels and the feedback tracker
// assumes: 50 MHz system clock, one clock domain
package cpf_pkg;

  // ---------------------------------------------------------------------------
  // field widths
  // ---------------------------------------------------------------------------
  localparam int DIV_W = 14;
  localparam int DUTY_W = 19;
  localparam int AVG_W = 13;
  localparam int SUM_W = 20;
  localparam int MM_W = 11;
  localparam int MM_LSB = AVG_W - MM_W;
  localparam int CNT_W = 24;
  localparam int ACC_W = 22;
  localparam int SHIFT_W = 4;

  // ---------------------------------------------------------------------------
  // reset values and limits
  // ---------------------------------------------------------------------------
  localparam logic [DIV_W-1:0] DIV_MIN = 14'h004f;
  localparam logic [DIV_W-1:0] DIV_RST = 14'h0271;
  localparam logic [DUTY_W-1:0] DUTY_RST = 19'h00000;
  localparam logic [CNT_W-1:0] LEN_RST = 24'h004e20;
  localparam logic [SHIFT_W-1:0] DUTY_BASE_SHIFT = 4'h5;

  // ---------------------------------------------------------------------------
  // timing figures
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ = 50000000;
  localparam int ADC_RATE_MAX_HZ = 128000;

  // ---------------------------------------------------------------------------
  // samples per pwm period
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SMP_32 = 2'b00,
    SMP_64 = 2'b01,
    SMP_128 = 2'b10,
    SMP_512 = 2'b11
  } cpf_samp_type;
  localparam cpf_samp_type SAMP_RST = SMP_32;
  localparam logic [SHIFT_W-1:0] SH_32 = 4'h5;
  localparam logic [SHIFT_W-1:0] SH_64 = 4'h6;
  localparam logic [SHIFT_W-1:0] SH_128 = 4'h7;
  localparam logic [SHIFT_W-1:0] SH_512 = 4'h9;

  // log2 of the samples-per-period value
  function automatic logic [SHIFT_W-1:0] samp_shift(input cpf_samp_type s);
    case (s)
      SMP_32: samp_shift = SH_32;
      SMP_64: samp_shift = SH_64;
      SMP_128: samp_shift = SH_128;
      default: samp_shift = SH_512;
    endcase
  endfunction : samp_shift

endpackage : cpf_pkg

//--- common/cpf_fb_if.sv
// cpf_fb_if.sv : per-cycle averages of the selected channel and the feedback results
// assumes: driven by cpf_chan_pwm, served by cpf_fb_track
`timescale 1ns/100ps
interface cpf_fb_if;
  import cpf_pkg::*;
  logic [AVG_W-1:0] cyc_avg;
  logic cyc_done;
  logic dither_zc;
  logic dither_on;
  logic avg_access;
  logic mm_access;
  logic chan_changed;
  logic [SUM_W-1:0] avg_sum;
  logic [MM_W-1:0] min_cur;
  logic [MM_W-1:0] max_cur;
  logic avg_valid;
  logic mm_valid;
  modport track (
    input cyc_avg, cyc_done, dither_zc, dither_on, avg_access, mm_access, chan_changed,
    output avg_sum, min_cur, max_cur, avg_valid, mm_valid
  );
  modport source (
    output cyc_avg, cyc_done, dither_zc, dither_on, avg_access, mm_access, chan_changed,
    input avg_sum, min_cur, max_cur, avg_valid, mm_valid
  );
endinterface : cpf_fb_if

//--- rtl/cpf_fb_track.sv
// cpf_fb_track.sv : dither-period sum and min/max of per-cycle current averages
// assumes: cyc_done pulses once per pwm period, dither_zc on the positive zero crossing
`timescale 1ns/100ps
module cpf_fb_track
  import cpf_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  cpf_fb_if.track fb
);

  typedef enum logic [0:0] {
    TRK_WAIT = 1'b0,
    TRK_RUN = 1'b1
  } cpf_trk_type;

  cpf_trk_type state_reg;
  logic [SUM_W-1:0] sum_reg;
  logic [AVG_W-1:0] min_reg;
  logic [AVG_W-1:0] max_reg;
  logic [SUM_W-1:0] sum_inc;
  logic [AVG_W-1:0] min_inc;
  logic [AVG_W-1:0] max_inc;
  logic store;

  // running values including the cycle that ends this clock
  always_comb begin
    sum_inc = sum_reg;
    min_inc = min_reg;
    max_inc = max_reg;
    if (fb.cyc_done) begin
      sum_inc = sum_reg + SUM_W'(fb.cyc_avg);
      min_inc = (fb.cyc_avg < min_reg) ? fb.cyc_avg : min_reg;
      max_inc = (fb.cyc_avg > max_reg) ? fb.cyc_avg : max_reg;
    end
  end

  // results are stored per period without dither, per dither period with it
  assign store = !fb.chan_changed &&
                 ((!fb.dither_on && fb.cyc_done) || (fb.dither_on && fb.dither_zc && state_reg == TRK_RUN));

  // ---------------------------------------------------------------------------
  // accumulation
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= TRK_WAIT;
      sum_reg <= '0;
      min_reg <= '1;
      max_reg <= '0;
    end else if (fb.chan_changed) begin
      state_reg <= TRK_WAIT;
      sum_reg <= '0;
      min_reg <= '1;
      max_reg <= '0;
    end else if (!fb.dither_on) begin
      // without dither nothing is gathered; once dither starts, the first period opens at a zero crossing
      state_reg <= TRK_WAIT;
      sum_reg <= '0;
      min_reg <= '1;
      max_reg <= '0;
    end else if (fb.dither_zc) begin
      state_reg <= TRK_RUN;
      sum_reg <= '0;
      min_reg <= '1;
      max_reg <= '0;
    end else if (state_reg == TRK_RUN) begin
      sum_reg <= sum_inc;
      min_reg <= min_inc;
      max_reg <= max_inc;
    end
  end

  // ---------------------------------------------------------------------------
  // results
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fb.avg_sum <= '0;
      fb.min_cur <= '0;
      fb.max_cur <= '0;
    end else if (store && !fb.dither_on) begin
      fb.avg_sum <= SUM_W'(fb.cyc_avg);
      fb.min_cur <= fb.cyc_avg[AVG_W-1:MM_LSB];
      fb.max_cur <= fb.cyc_avg[AVG_W-1:MM_LSB];
    end else if (store) begin
      fb.avg_sum <= sum_inc;
      fb.min_cur <= min_inc[AVG_W-1:MM_LSB];
      fb.max_cur <= max_inc[AVG_W-1:MM_LSB];
    end
  end

  // set wins over the clear of an access in the same cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fb.avg_valid <= 1'b0;
      fb.mm_valid <= 1'b0;
    end else begin
      fb.avg_valid <= store ? 1'b1 : (fb.avg_access ? 1'b0 : fb.avg_valid);
      fb.mm_valid <= store ? 1'b1 : (fb.mm_access ? 1'b0 : fb.mm_valid);
    end
  end

endmodule : cpf_fb_track

//--- rtl/cpf_chan_pwm.sv
// cpf_chan_pwm.sv : direct pwm gate drive for every channel plus current feedback capture
// assumes: configuration strobes, converter samples and dither events synchronous to clock
`timescale 1ns/100ps
module cpf_chan_pwm
  import cpf_pkg::*;
#(
  parameter int NUM_CHAN = 8,
  parameter int CHAN_W = 3
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [CHAN_W-1:0] cfg_chan,
  input wire logic period_wr,
  input wire logic [DIV_W-1:0] period_div_in,
  input wire logic samples_wr,
  input wire logic [1:0] samples_code_in,
  input wire logic duty_wr,
  input wire logic [DUTY_W-1:0] duty_in,
  input wire logic [NUM_CHAN-1:0] direct_mode,
  input wire logic [NUM_CHAN-1:0] sense_valid,
  input wire logic [NUM_CHAN-1:0][AVG_W-1:0] sense_data,
  input wire logic [NUM_CHAN-1:0] dither_on,
  input wire logic [NUM_CHAN-1:0] dither_zc,
  input wire logic avg_access,
  input wire logic mm_access,
  input wire logic [CHAN_W-1:0] fb_chan_in,
  output logic [NUM_CHAN-1:0] gate_drive_output,
  output logic [NUM_CHAN-1:0] pi_integ_clear,
  output logic [NUM_CHAN-1:0] pi_loop_en,
  output logic [NUM_CHAN-1:0][DIV_W-1:0] period_div_readback,
  output logic [NUM_CHAN-1:0][1:0] samples_code_readback,
  output logic [NUM_CHAN-1:0][DUTY_W-1:0] duty_readback,
  output logic [NUM_CHAN-1:0][AVG_W-1:0] cycle_avg,
  output logic [NUM_CHAN-1:0] cycle_done,
  output logic [CHAN_W-1:0] fb_chan,
  output logic [SUM_W-1:0] avg_sum,
  output logic avg_valid,
  output logic [MM_W-1:0] min_cur,
  output logic [MM_W-1:0] max_cur,
  output logic mm_valid
);

  // ---------------------------------------------------------------------------
  // shared feedback selection
  // ---------------------------------------------------------------------------
  cpf_fb_if fb ();

  logic [CHAN_W-1:0] fb_chan_reg;
  logic fb_access;
  logic [NUM_CHAN-1:0][AVG_W-1:0] avg_all;
  logic [NUM_CHAN-1:0] done_all;

  assign fb_access = avg_access || mm_access;

  // either access selects the channel for both functions
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fb_chan_reg <= '0;
    end else if (fb_access) begin
      fb_chan_reg <= fb_chan_in;
    end
  end

  assign fb.chan_changed = fb_access && (fb_chan_in != fb_chan_reg);
  assign fb.avg_access = avg_access;
  assign fb.mm_access = mm_access;
  assign fb.cyc_avg = avg_all[fb_chan_reg];
  assign fb.cyc_done = done_all[fb_chan_reg];
  assign fb.dither_on = dither_on[fb_chan_reg];
  assign fb.dither_zc = dither_zc[fb_chan_reg];

  cpf_fb_track u_track (
    .clock(clock),
    .rstn(rstn),
    .fb(fb.track)
  );

  assign fb_chan = fb_chan_reg;
  assign avg_sum = fb.avg_sum;
  assign avg_valid = fb.avg_valid;
  assign min_cur = fb.min_cur;
  assign max_cur = fb.max_cur;
  assign mm_valid = fb.mm_valid;
  assign cycle_avg = avg_all;
  assign cycle_done = done_all;

  // ---------------------------------------------------------------------------
  // per-channel pwm generation and cycle averaging
  // ---------------------------------------------------------------------------
  for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan

    logic sel;
    logic [DIV_W-1:0] div_pend_reg;
    cpf_samp_type samp_pend_reg;
    cpf_samp_type samp_act_reg;
    logic [DUTY_W-1:0] duty_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] len_reg;
    logic [CNT_W-1:0] on_reg;
    logic [CNT_W-1:0] len_next;
    logic [CNT_W-1:0] on_raw;
    logic [CNT_W-1:0] on_next;
    logic [CNT_W-1:0] cnt_inc;
    logic [SHIFT_W-1:0] sh_pend;
    logic [SHIFT_W-1:0] sh_act;
    logic last;
    logic [ACC_W-1:0] acc_reg;
    logic [ACC_W-1:0] acc_next;
    logic [ACC_W-1:0] avg_wide;
    logic [AVG_W-1:0] avg_reg;
    logic done_reg;
    logic gate_reg;
    logic integ_clr_reg;
    logic loop_en_reg;

    assign sel = (cfg_chan == CHAN_W'(c));

    // -------------------------------------------------------------------------
    // configuration held for the host
    // -------------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        div_pend_reg <= DIV_RST;
      end else if (period_wr && sel) begin
        div_pend_reg <= (period_div_in < DIV_MIN) ? DIV_MIN : period_div_in;
      end
    end

    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        samp_pend_reg <= SAMP_RST;
      end else if (samples_wr && sel) begin
        samp_pend_reg <= cpf_samp_type'(samples_code_in);
      end
    end

    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        duty_reg <= DUTY_RST;
      end else if (duty_wr && sel) begin
        duty_reg <= duty_in;
      end
    end

    // the readback shows the written, already clamped values at once
    assign period_div_readback[c] = div_pend_reg;
    assign samples_code_readback[c] = samp_pend_reg;
    assign duty_readback[c] = duty_reg;

    // -------------------------------------------------------------------------
    // direct mode keeps the current loop off
    // -------------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        integ_clr_reg <= 1'b0;
        loop_en_reg <= 1'b0;
      end else begin
        integ_clr_reg <= direct_mode[c];
        loop_en_reg <= !direct_mode[c];
      end
    end

    assign pi_integ_clear[c] = integ_clr_reg;
    assign pi_loop_en[c] = loop_en_reg;

    // -------------------------------------------------------------------------
    // period and on-time for the coming period
    // -------------------------------------------------------------------------
    assign sh_pend = samp_shift(samp_pend_reg);
    assign sh_act = samp_shift(samp_act_reg);
    assign len_next = CNT_W'(div_pend_reg) << sh_pend;
    assign on_raw = CNT_W'(duty_reg) << (sh_pend - DUTY_BASE_SHIFT);
    assign on_next = (on_raw > len_next) ? len_next : on_raw;
    assign cnt_inc = cnt_reg + CNT_W'(1);
    assign last = (cnt_inc == len_reg);

    // new settings take effect only at a period boundary
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        len_reg <= LEN_RST;
        on_reg <= '0;
        samp_act_reg <= SAMP_RST;
      end else if (last) begin
        len_reg <= len_next;
        on_reg <= on_next;
        samp_act_reg <= samp_pend_reg;
      end
    end

    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        cnt_reg <= '0;
      end else if (last) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_inc;
      end
    end

    // -------------------------------------------------------------------------
    // gate drive
    // -------------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        gate_reg <= 1'b0;
      end else if (last) begin
        gate_reg <= (on_next != '0);
      end else begin
        gate_reg <= (cnt_inc < on_reg);
      end
    end

    assign gate_drive_output[c] = gate_reg;

    // -------------------------------------------------------------------------
    // average current over the period
    // -------------------------------------------------------------------------
    assign acc_next = acc_reg + (sense_valid[c] ? ACC_W'(sense_data[c]) : ACC_W'(0));
    assign avg_wide = acc_next >> sh_act;

    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        acc_reg <= '0;
      end else if (last) begin
        acc_reg <= '0;
      end else begin
        acc_reg <= acc_next;
      end
    end

    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        avg_reg <= '0;
        done_reg <= 1'b0;
      end else begin
        done_reg <= last;
        if (last) begin
          avg_reg <= (avg_wide > ACC_W'({AVG_W{1'b1}})) ? '1 : avg_wide[AVG_W-1:0];
        end
      end
    end

    assign avg_all[c] = avg_reg;
    assign done_all[c] = done_reg;

  end : g_chan

endmodule : cpf_chan_pwm

//--- sim/cpf_chan_pwm_checker.sv
// cpf_chan_pwm_checker.sv : port-level assertions for the direct pwm and feedback block
// assumes: bound to cpf_chan_pwm, single clock domain
`timescale 1ns/100ps
module cpf_chan_pwm_checker
  import cpf_pkg::*;
#(
  parameter int NUM_CHAN = 8,
  parameter int CHAN_W = 3
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [CHAN_W-1:0] cfg_chan,
  input wire logic period_wr,
  input wire logic [DIV_W-1:0] period_div_in,
  input wire logic [NUM_CHAN-1:0] direct_mode,
  input wire logic [NUM_CHAN-1:0] dither_on,
  input wire logic [NUM_CHAN-1:0] dither_zc,
  input wire logic avg_access,
  input wire logic mm_access,
  input wire logic [CHAN_W-1:0] fb_chan_in,
  input wire logic [NUM_CHAN-1:0] pi_integ_clear,
  input wire logic [NUM_CHAN-1:0] pi_loop_en,
  input wire logic [NUM_CHAN-1:0][DIV_W-1:0] period_div_readback,
  input wire logic [NUM_CHAN-1:0][AVG_W-1:0] cycle_avg,
  input wire logic [NUM_CHAN-1:0] cycle_done,
  input wire logic [CHAN_W-1:0] fb_chan,
  input wire logic [SUM_W-1:0] avg_sum,
  input wire logic avg_valid,
  input wire logic [MM_W-1:0] min_cur,
  input wire logic [MM_W-1:0] max_cur,
  input wire logic mm_valid
);
  logic [AVG_W-1:0] sel_avg;
  logic [MM_W-1:0] sel_mm;
  logic quiet;
  assign sel_avg = cycle_avg[fb_chan];
  assign sel_mm = sel_avg[AVG_W-1:MM_LSB];
  assign quiet = !(|cycle_done) && !(|dither_zc);
  // ----------
  // assertions
  // ----------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  chk_div_clamp: assert property (
    period_wr && period_div_in < DIV_MIN |=> period_div_readback[$past(cfg_chan)] == DIV_MIN)
    else $error("short divider not raised to floor");
  chk_div_keep: assert property (
    period_wr && period_div_in >= DIV_MIN |=> period_div_readback[$past(cfg_chan)] == $past(period_div_in))
    else $error("divider readback differs from written value");
  chk_direct_hold: assert property (
    direct_mode[0] |=> pi_integ_clear[0] && !pi_loop_en[0])
    else $error("loop not held off in direct mode");
  chk_avg_follow: assert property (
    cycle_done[fb_chan] && !dither_on[fb_chan] && !avg_access && !mm_access
    |=> avg_sum == SUM_W'($past(sel_avg)) && avg_valid)
    else $error("undithered sum not the cycle average");
  chk_mm_follow: assert property (
    cycle_done[fb_chan] && !dither_on[fb_chan] && !avg_access && !mm_access
    |=> min_cur == $past(sel_mm) && max_cur == $past(sel_mm) && mm_valid)
    else $error("undithered min or max not the cycle average");
  chk_avg_clear: assert property (
    avg_access && quiet |=> !avg_valid)
    else $error("sum valid not cleared by access");
  chk_mm_clear: assert property (
    mm_access && quiet |=> !mm_valid)
    else $error("min max valid not cleared by access");
  chk_chan_pick: assert property (
    avg_access || mm_access |=> fb_chan == $past(fb_chan_in))
    else $error("feedback channel not taken from access");
  chk_min_le_max: assert property (
    mm_valid |-> min_cur <= max_cur)
    else $error("minimum above maximum");
endmodule : cpf_chan_pwm_checker

//--- sim/cpf_gate_load.sv
// cpf_gate_load.sv : external gate as a timing probe plus a current-sense sample source
// assumes: one gate pin per instance, sample stream shared by all channels
`timescale 1ns/100ps
module cpf_gate_load
  import cpf_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic gate,
  output logic sense_valid,
  output logic [AVG_W-1:0] sense_data,
  output logic [CNT_W-1:0] period_seen,
  output logic [CNT_W-1:0] on_seen,
  output logic [CNT_W-1:0] high_run
);
  logic gate_reg;
  logic [CNT_W-1:0] since_rise;
  logic [8:0] tick_reg;
  // ----------
  // gate timing
  // ----------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gate_reg <= 1'b0;
      since_rise <= '0;
      period_seen <= '0;
      on_seen <= '0;
      high_run <= '0;
    end else begin
      gate_reg <= gate;
      since_rise <= since_rise + 1'b1;
      high_run <= gate ? high_run + 1'b1 : 24'h000000;
      if (gate && !gate_reg) begin
        period_seen <= since_rise;
        since_rise <= 24'h000001;
      end
      if (!gate && gate_reg) begin
        on_seen <= since_rise;
      end
    end
  end
  // ----------
  // sense samples, one per 391 clocks so the converter rate stays legal
  // ----------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tick_reg <= '0;
      sense_valid <= 1'b0;
      sense_data <= '0;
    end else if (tick_reg == 9'h186) begin
      tick_reg <= '0;
      sense_valid <= 1'b1;
      sense_data <= gate_reg ? 13'h0a00 : 13'h0100;
    end else begin
      tick_reg <= tick_reg + 1'b1;
      sense_valid <= 1'b0;
    end
  end
endmodule : cpf_gate_load

//--- sim/testbench.sv
// testbench.sv : self-checking bench for the direct pwm channels and current feedback
// assumes: package, design, gate load model and checker compiled before this file
`timescale 1ns/100ps
module testbench;
  import cpf_pkg::*;
  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic [1:0] code;
    logic [DIV_W-1:0] div_exp;
  } cpf_row_type;
  localparam cpf_row_type ROWS [5] = '{'{14'h000a, 2'b00, 14'h004f}, '{14'h004e, 2'b01, 14'h004f},
    '{14'h004f, 2'b10, 14'h004f}, '{14'h3fff, 2'b11, 14'h3fff}, '{14'h0050, 2'b01, 14'h0050}};
  localparam int LIMIT = 90000;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] cfg_chan = 3'h0;
  logic period_wr = 1'b0;
  logic samples_wr = 1'b0;
  logic duty_wr = 1'b0;
  logic [DIV_W-1:0] period_div_in = 14'h0000;
  logic [1:0] samples_code_in = 2'b00;
  logic [DUTY_W-1:0] duty_in = 19'h00000;
  logic [7:0] direct_mode = 8'h00;
  logic [7:0] dither_on = 8'h00;
  logic [7:0] dither_zc = 8'h00;
  logic avg_access = 1'b0;
  logic mm_access = 1'b0;
  logic [2:0] fb_chan_in = 3'h0;
  logic sv;
  logic [AVG_W-1:0] sd;
  logic [7:0] gate_drive_output, pi_integ_clear, pi_loop_en;
  logic [7:0][DIV_W-1:0] period_div_readback;
  logic [7:0][1:0] samples_code_readback;
  logic [7:0][DUTY_W-1:0] duty_readback;
  logic [2:0] fb_chan;
  logic [SUM_W-1:0] avg_sum;
  logic avg_valid, mm_valid;
  logic [MM_W-1:0] min_cur, max_cur;
  logic [CNT_W-1:0] p0_period, p0_on, p1_run;
  int bad_count = 0;
  int check_count = 0;
  int cycle_count = 0;
  // ----------
  // design and load models
  // ----------
  cpf_chan_pwm u_dut (.clock, .rstn, .cfg_chan, .period_wr, .period_div_in, .samples_wr, .samples_code_in,
    .duty_wr, .duty_in, .direct_mode, .sense_valid({8{sv}}), .sense_data({8{sd}}), .dither_on, .dither_zc,
    .avg_access, .mm_access, .fb_chan_in, .gate_drive_output, .pi_integ_clear, .pi_loop_en,
    .period_div_readback, .samples_code_readback, .duty_readback, .cycle_avg(), .cycle_done(), .fb_chan,
    .avg_sum, .avg_valid, .min_cur, .max_cur, .mm_valid);
  cpf_gate_load u_load0 (.clock, .rstn, .gate(gate_drive_output[0]), .sense_valid(sv), .sense_data(sd),
    .period_seen(p0_period), .on_seen(p0_on), .high_run());
  cpf_gate_load u_load1 (.clock, .rstn, .gate(gate_drive_output[1]), .sense_valid(), .sense_data(),
    .period_seen(), .on_seen(), .high_run(p1_run));
  // ----------
  // tasks
  // ----------
  task automatic check(input string what, input logic [CNT_W-1:0] seen, input logic [CNT_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cfg(input logic [2:0] ch, input logic [2:0] which, input logic [18:0] val);
    @(posedge clock);
    cfg_chan <= ch;
    period_div_in <= val[13:0];
    samples_code_in <= val[1:0];
    duty_in <= val;
    {duty_wr, samples_wr, period_wr} <= which;
    @(posedge clock);
    {duty_wr, samples_wr, period_wr} <= 3'h0;
  endtask : cfg
  task automatic acc(input logic a, input logic m, input logic [2:0] ch);
    @(posedge clock);
    {avg_access, mm_access, fb_chan_in} <= {a, m, ch};
    @(posedge clock);
    {avg_access, mm_access} <= 2'b00;
  endtask : acc
  task automatic zc(input logic [7:0] mask);
    @(posedge clock);
    dither_zc <= mask;
    @(posedge clock);
    dither_zc <= 8'h00;
    repeat (3) @(posedge clock);
    #1;
  endtask : zc
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cycle_count++;
    if (cycle_count == LIMIT) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // ----------
  // sequence
  // ----------
  initial begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    #1;
    for (int k = 0; k < 8; k++) begin
      check("div reset", period_div_readback[k], DIV_RST);
      check("samples reset", samples_code_readback[k], 2'b00);
    end
    check("gate reset", gate_drive_output, 8'h00);
    for (int i = 0; i < 5; i++) begin
      cfg(i[2:0], 3'h1, {5'h00, ROWS[i].div});
      cfg(i[2:0], 3'h2, {17'h00000, ROWS[i].code});
      #1;
      check("divider", period_div_readback[i], ROWS[i].div_exp);
      check("samples", samples_code_readback[i], ROWS[i].code);
    end
    cfg(3'h0, 3'h1, 19'h00187);
    cfg(3'h0, 3'h2, 19'h00001);
    cfg(3'h0, 3'h4, 19'h00064);
    cfg(3'h1, 3'h1, 19'h00187);
    cfg(3'h1, 3'h2, 19'h00000);
    cfg(3'h1, 3'h4, 19'h7ffff);
    direct_mode <= 8'h0f;
    repeat (2) @(posedge clock);
    #1;
    check("duty", duty_readback[0], 19'h00064);
    check("integ clear", pi_integ_clear, 8'h0f);
    check("loop enable", pi_loop_en, 8'hf0);
    acc(1'b1, 1'b0, 3'h1);
    #1;
    check("chan", fb_chan, 3'h1);
    for (int n = 0; n < 34000 && avg_valid !== 1'b1; n++) @(posedge clock);
    #1;
    check("sum valid", avg_valid, 1'b1);
    check("sum width", avg_sum[19:13], 7'h00);
    check("min", min_cur, avg_sum[12:2]);
    check("max", max_cur, min_cur);
    while (cycle_count < 45500) @(posedge clock);
    #1;
    check("period", p0_period, 24'h0061c0);
    check("on time", p0_on, 24'h0000c8);
    check("full duty", p1_run > 24'h0030e0, 1'b1);
    check("avg value", avg_sum, 24'h000100);
    check("min value", min_cur, 24'h000040);
    check("max value", max_cur, 24'h000040);
    @(posedge clock);
    dither_on <= 8'h06;
    acc(1'b1, 1'b1, 3'h1);
    #1;
    check("sum cleared", avg_valid, 1'b0);
    check("mm cleared", mm_valid, 1'b0);
    zc(8'h02);
    repeat (13000) @(posedge clock);
    zc(8'h02);
    check("dither sum", avg_valid, 1'b1);
    check("dither mm", mm_valid, 1'b1);
    check("dither sum value", avg_sum, 24'h000100);
    check("dither min value", min_cur, 24'h000040);
    check("dither max value", max_cur, 24'h000040);
    acc(1'b1, 1'b1, 3'h2);
    zc(8'h04);
    check("new chan wait", avg_valid, 1'b0);
    check("new chan mm wait", mm_valid, 1'b0);
    repeat (10500) @(posedge clock);
    zc(8'h04);
    check("new chan sum", avg_valid, 1'b1);
    check("new chan mm", mm_valid, 1'b1);
    tally_and_finish();
  end
endmodule : testbench
bind cpf_chan_pwm cpf_chan_pwm_checker #(.NUM_CHAN(NUM_CHAN), .CHAN_W(CHAN_W)) u_chk (.clock, .rstn,
  .cfg_chan, .period_wr, .period_div_in, .direct_mode, .dither_on, .dither_zc, .avg_access, .mm_access,
  .fb_chan_in, .pi_integ_clear, .pi_loop_en, .period_div_readback, .cycle_avg, .cycle_done, .fb_chan,
  .avg_sum, .avg_valid, .min_cur, .max_cur, .mm_valid);
